/* File: verilog/spi_eeprom_defs.svh */
// Shared constants for the serial memory link and both of its ends
`ifndef SPI_EEPROM_DEFS_SVH
`define SPI_EEPROM_DEFS_SVH

// ----------------------------------------------------------------
// Frame shape
// ----------------------------------------------------------------
`define BYTE_BITS 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS 20
`define SCK_PERIOD_NS 320
`define SCK_HALF_CYC (`SCK_PERIOD_NS / (2 * `MCLK_PERIOD_NS))
`define DIV_W 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PROTECT_RESET 1'b0
// Select and clock start low so a low select through reset shows no edge
`define PIN_SYNC_RESET 5'h18

`endif

/* File: verilog/spi_eeprom_pkg.sv */
// Types shared by the two ends of the serial memory link
package spi_eeprom_pkg;

    // ----------------------------------------------------------------
    // Device end states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_ACTIVE,
        DEV_HOLD
    } dev_state_e;

    // ----------------------------------------------------------------
    // Master end states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        M_IDLE,
        M_LOW,
        M_HIGH,
        M_END
    } mst_state_e;

endpackage

/* File: verilog/spi_eeprom_if.sv */
// Link pins between the bus master and the memory front end
`timescale 1ns/100ps
interface spi_eeprom_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic hold_n;
    logic wp_n;
    logic miso_line;

    // Undriven data line sits at the pull-up level
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (
        input sck,
        input cs_n,
        input mosi,
        input hold_n,
        input wp_n,
        output miso,
        output miso_oe
    );

    modport master (
        output sck,
        output cs_n,
        output mosi,
        output hold_n,
        output wp_n,
        input miso_line
    );
endinterface

/* File: verilog/spi_eeprom_dev.sv */
// Memory-side front end of the serial link
`timescale 1ns/100ps
`include "spi_eeprom_defs.svh"

module spi_eeprom_dev (
    input wire logic mclk_i,
    input wire logic resetn_i,
    spi_eeprom_if.dev link,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_en_i,
    input wire logic status_wr_i,
    input wire logic [1:0] status_bp_i,
    input wire logic write_busy_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic rx_first_o,
    output logic tx_load_o,
    output logic selected_o,
    output logic hold_o,
    output logic standby_o,
    output logic iface_reset_o,
    output logic protect_level_hi_o,
    output logic protect_level_lo_o
);

    // ----------------------------------------------------------------
    // Pin synchronisers: {wp_n, hold_n, mosi, cs_n, sck}
    // ----------------------------------------------------------------
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_d_reg;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_reg <= `PIN_SYNC_RESET;
            pin_s2_reg <= `PIN_SYNC_RESET;
            pin_d_reg <= `PIN_SYNC_RESET;
        end else begin
            pin_s1_reg <= {link.wp_n, link.hold_n, link.mosi, link.cs_n, link.sck};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end

    wire sck_lvl = pin_s2_reg[0];
    wire cs_n_lvl = pin_s2_reg[1];
    wire mosi_lvl = pin_s2_reg[2];
    wire hold_n_lvl = pin_s2_reg[3];
    wire wp_n_lvl = pin_s2_reg[4];
    wire sck_rise = sck_lvl & ~pin_d_reg[0];
    wire sck_fall = ~sck_lvl & pin_d_reg[0];
    wire cs_fall = ~cs_n_lvl & pin_d_reg[1];
    // Hold taken only with the clock low so no edge is lost or invented
    wire hold_enter = ~hold_n_lvl & ~sck_lvl;
    wire hold_leave = hold_n_lvl & ~sck_lvl;

    // ----------------------------------------------------------------
    // State and shift registers
    // ----------------------------------------------------------------
    spi_eeprom_pkg::dev_state_e state_reg;
    spi_eeprom_pkg::dev_state_e state_next;
    logic [`BIT_CNT_W-1:0] bit_cnt_reg;
    logic [`BIT_CNT_W-1:0] bit_cnt_next;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_sh_next;
    logic [7:0] tx_sh_reg;
    logic [7:0] tx_sh_next;
    logic any_byte_reg;
    logic any_byte_next;
    logic out_on_reg;
    logic out_on_next;
    logic miso_reg;
    logic miso_next;
    logic miso_oe_reg;
    logic rx_valid_next;
    logic tx_load_next;
    logic iface_reset_next;
    logic protect_hi_reg;
    logic protect_lo_reg;

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        rx_sh_next = rx_sh_reg;
        tx_sh_next = tx_sh_reg;
        any_byte_next = any_byte_reg;
        out_on_next = out_on_reg;
        miso_next = miso_reg;
        rx_valid_next = 1'b0;
        tx_load_next = 1'b0;
        iface_reset_next = 1'b0;
        case (state_reg)
            spi_eeprom_pkg::DEV_IDLE: begin
                // Only a seen falling select starts a command
                bit_cnt_next = `BIT_FIRST;
                any_byte_next = 1'b0;
                out_on_next = 1'b0;
                if (cs_fall) begin
                    state_next = spi_eeprom_pkg::DEV_ACTIVE;
                end
            end
            spi_eeprom_pkg::DEV_ACTIVE: begin
                if (cs_n_lvl) begin
                    state_next = spi_eeprom_pkg::DEV_IDLE;
                    out_on_next = 1'b0;
                end else if (hold_enter) begin
                    state_next = spi_eeprom_pkg::DEV_HOLD;
                end else if (sck_rise) begin
                    rx_sh_next = {rx_sh_reg[6:0], mosi_lvl};
                    bit_cnt_next = bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == `BIT_LAST) begin
                        rx_valid_next = 1'b1;
                        any_byte_next = 1'b1;
                    end
                end else if (sck_fall) begin
                    if (bit_cnt_reg == `BIT_FIRST && any_byte_reg && tx_en_i) begin
                        miso_next = tx_data_i[7];
                        tx_sh_next = {tx_data_i[6:0], 1'b0};
                        out_on_next = 1'b1;
                        tx_load_next = 1'b1;
                    end else if (bit_cnt_reg == `BIT_FIRST && !tx_en_i) begin
                        out_on_next = 1'b0;
                    end else if (out_on_reg) begin
                        miso_next = tx_sh_reg[7];
                        tx_sh_next = {tx_sh_reg[6:0], 1'b0};
                    end
                end
            end
            spi_eeprom_pkg::DEV_HOLD: begin
                // Clock and data ignored; counters frozen
                if (cs_n_lvl) begin
                    state_next = spi_eeprom_pkg::DEV_IDLE;
                    out_on_next = 1'b0;
                    iface_reset_next = 1'b1;
                end else if (hold_leave) begin
                    state_next = spi_eeprom_pkg::DEV_ACTIVE;
                end
            end
            default: begin
                state_next = spi_eeprom_pkg::DEV_IDLE;
            end
        endcase
    end

    // Output only driven while selected, not held, and sending
    wire oe_next = (state_next == spi_eeprom_pkg::DEV_ACTIVE) & out_on_next;
    // Protect level is frozen while the protect pin is low
    wire protect_wr = status_wr_i & wp_n_lvl;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= spi_eeprom_pkg::DEV_IDLE;
            bit_cnt_reg <= `BIT_FIRST;
            rx_sh_reg <= 8'h00;
            tx_sh_reg <= 8'h00;
            any_byte_reg <= 1'b0;
            out_on_reg <= 1'b0;
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_sh_reg <= rx_sh_next;
            tx_sh_reg <= tx_sh_next;
            any_byte_reg <= any_byte_next;
            out_on_reg <= out_on_next;
            miso_reg <= miso_next;
            miso_oe_reg <= oe_next;
        end
    end

    // ----------------------------------------------------------------
    // User side outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_byte_o <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_first_o <= 1'b0;
            tx_load_o <= 1'b0;
            selected_o <= 1'b0;
            hold_o <= 1'b0;
            standby_o <= 1'b1;
            iface_reset_o <= 1'b0;
        end else begin
            rx_byte_o <= rx_valid_next ? rx_sh_next : rx_byte_o;
            rx_valid_o <= rx_valid_next;
            rx_first_o <= rx_valid_next ? ~any_byte_reg : rx_first_o;
            tx_load_o <= tx_load_next;
            selected_o <= state_next != spi_eeprom_pkg::DEV_IDLE;
            hold_o <= state_next == spi_eeprom_pkg::DEV_HOLD;
            standby_o <= (state_next == spi_eeprom_pkg::DEV_IDLE) & ~write_busy_i;
            iface_reset_o <= iface_reset_next;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            protect_hi_reg <= `PROTECT_RESET;
            protect_lo_reg <= `PROTECT_RESET;
        end else if (protect_wr) begin
            protect_hi_reg <= status_bp_i[1];
            protect_lo_reg <= status_bp_i[0];
        end
    end

    assign protect_level_hi_o = protect_hi_reg;
    assign protect_level_lo_o = protect_lo_reg;
    assign link.miso = miso_reg;
    assign link.miso_oe = miso_oe_reg;

endmodule // spi_eeprom_dev

/* File: verilog/spi_eeprom_master.sv */
// Bus master end of the serial memory link
`timescale 1ns/100ps
`include "spi_eeprom_defs.svh"

module spi_eeprom_master (
    input wire logic mclk_i,
    input wire logic resetn_i,
    spi_eeprom_if.master link,
    input wire logic start_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic last_i,
    input wire logic cpol_i,
    input wire logic hold_req_i,
    input wire logic wp_i,
    output logic busy_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o
);

    // ----------------------------------------------------------------
    // Data line synchroniser
    // ----------------------------------------------------------------
    logic miso_s1_reg;
    logic miso_s2_reg;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            miso_s1_reg <= 1'b1;
            miso_s2_reg <= 1'b1;
        end else begin
            miso_s1_reg <= link.miso_line;
            miso_s2_reg <= miso_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    spi_eeprom_pkg::mst_state_e state_reg;
    logic [`DIV_W-1:0] div_reg;
    logic [`BIT_CNT_W-1:0] bit_cnt_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic last_reg;
    logic cpol_reg;
    logic sck_reg;
    logic cs_n_reg;
    logic mosi_reg;
    logic hold_n_reg;
    logic wp_n_reg;

    wire div_done = div_reg == `DIV_W'(`SCK_HALF_CYC - 1);
    // Slow half periods leave room for both pin synchronisers
    wire in_idle = state_reg == spi_eeprom_pkg::M_IDLE;
    wire frame_off = in_idle & cs_n_reg;
    // Hold only offered in the low phase of a selected frame
    wire hold_now = (state_reg == spi_eeprom_pkg::M_LOW) & hold_req_i;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= spi_eeprom_pkg::M_IDLE;
            div_reg <= `DIV_W'(0);
            bit_cnt_reg <= `BIT_FIRST;
            tx_sh_reg <= 8'h00;
            rx_sh_reg <= 8'h00;
            last_reg <= 1'b0;
            cpol_reg <= 1'b0;
            sck_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            mosi_reg <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_byte_o <= 8'h00;
        end else begin
            rx_valid_o <= 1'b0;
            case (state_reg)
                spi_eeprom_pkg::M_IDLE: begin
                    if (frame_off) begin
                        cpol_reg <= cpol_i;
                        sck_reg <= cpol_i;
                    end
                    if (start_i) begin
                        cs_n_reg <= 1'b0;
                        mosi_reg <= tx_byte_i[7];
                        tx_sh_reg <= {tx_byte_i[6:0], 1'b0};
                        last_reg <= last_i;
                        sck_reg <= 1'b0;
                        div_reg <= `DIV_W'(0);
                        bit_cnt_reg <= `BIT_FIRST;
                        state_reg <= spi_eeprom_pkg::M_LOW;
                    end
                end
                spi_eeprom_pkg::M_LOW: begin
                    if (!hold_now) begin
                        div_reg <= div_reg + `DIV_W'(1);
                        if (div_done) begin
                            sck_reg <= 1'b1;
                            rx_sh_reg <= {rx_sh_reg[6:0], miso_s2_reg};
                            div_reg <= `DIV_W'(0);
                            state_reg <= spi_eeprom_pkg::M_HIGH;
                        end
                    end else begin
                        // Full low phase after a pause lets the returning data settle
                        div_reg <= `DIV_W'(0);
                    end
                end
                spi_eeprom_pkg::M_HIGH: begin
                    div_reg <= div_reg + `DIV_W'(1);
                    if (div_done) begin
                        div_reg <= `DIV_W'(0);
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == `BIT_LAST) begin
                            rx_valid_o <= 1'b1;
                            rx_byte_o <= rx_sh_reg;
                            sck_reg <= cpol_reg;
                            state_reg <= last_reg ? spi_eeprom_pkg::M_END
                                                  : spi_eeprom_pkg::M_IDLE;
                        end else begin
                            sck_reg <= 1'b0;
                            mosi_reg <= tx_sh_reg[7];
                            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                            state_reg <= spi_eeprom_pkg::M_LOW;
                        end
                    end
                end
                spi_eeprom_pkg::M_END: begin
                    div_reg <= div_reg + `DIV_W'(1);
                    if (div_done) begin
                        div_reg <= `DIV_W'(0);
                        cs_n_reg <= 1'b1;
                        state_reg <= spi_eeprom_pkg::M_IDLE;
                    end
                end
                default: begin
                    state_reg <= spi_eeprom_pkg::M_IDLE;
                end
            endcase
        end
    end

    // Protect pin follows wp_i only while idle and deselected, so it can also change on the edge a frame starts
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_n_reg <= 1'b1;
            hold_n_reg <= 1'b1;
            busy_o <= 1'b0;
        end else begin
            wp_n_reg <= frame_off ? ~wp_i : wp_n_reg;
            hold_n_reg <= ~hold_now;
            busy_o <= ~in_idle | start_i;
        end
    end

    assign link.sck = sck_reg;
    assign link.cs_n = cs_n_reg;
    assign link.mosi = mosi_reg;
    assign link.hold_n = hold_n_reg;
    assign link.wp_n = wp_n_reg;

endmodule // spi_eeprom_master

/* File: testbench/spi_eeprom_monitor.sv */
// Concurrent checks on the pins between the two link ends
`timescale 1ns/100ps
module spi_eeprom_monitor (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic hold_n,
    input wire logic wp_n
);
    // ----------------------------------------------------------------
    // Clocking
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Six cycles covers the pin synchroniser delay
    a_out_released_deselect: assert property (cs_n [*6] |-> !miso_oe)
        else $error("data output driven while deselected");
    a_miso_moves_low: assert property (
        miso_oe && $past(miso_oe) && $changed(miso) |-> !sck)
        else $error("data output changed outside clock low phase");
    a_mosi_steady_high: assert property (
        sck && $past(sck) && !cs_n |-> $stable(mosi))
        else $error("data input moved while clock high");
    a_hold_releases_out: assert property (!hold_n [*6] |-> !miso_oe)
        else $error("data output driven during pause");
    a_hold_needs_select: assert property (!hold_n |-> !cs_n)
        else $error("pause asserted while deselected");
    a_wp_steady_frame: assert property ($changed(wp_n) |-> cs_n)
        else $error("write protect moved inside a frame");
    a_high_phase_len: assert property ($rose(sck) && !cs_n |-> sck [*8])
        else $error("clock high phase too short");
    a_no_early_output: assert property ($fell(cs_n) |-> !miso_oe [*8])
        else $error("output driven before a byte was received");
    a_output_starts_fall: assert property (
        $rose(miso_oe) |-> !sck && !$past(sck, 2))
        else $error("output enabled outside clock low phase");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    c_pause: cover property ($fell(hold_n));
    c_read_out: cover property ($rose(miso_oe));
    c_frame_end: cover property ($rose(cs_n));
endmodule // spi_eeprom_monitor

/* File: testbench/tb.sv */
// Self-checking bench joining the bus master end to the memory end
`timescale 1ns/100ps
module tb;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic start_i = 1'b0;
    logic [7:0] tx_byte_i = 8'h00;
    logic last_i = 1'b0;
    logic cpol_i = 1'b0;
    logic hold_req_i = 1'b0;
    logic wp_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic tx_en_i = 1'b0;
    logic status_wr_i = 1'b0;
    logic [1:0] status_bp_i = 2'h0;
    logic write_busy_i = 1'b0;
    logic busy_o, m_valid, d_valid, d_first, sel, standby_o, hold_o, bp_hi, bp_lo;
    logic [7:0] m_byte, d_byte, m_got, d_got;
    logic d_first_got;
    int n_errors = 0;
    int total_checks = 0;
    int seed_ret;

    spi_eeprom_if link_a ();
    spi_eeprom_master u_spi_eeprom_master (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .link(link_a.master), .start_i(start_i), .tx_byte_i(tx_byte_i), .last_i(last_i),
        .cpol_i(cpol_i), .hold_req_i(hold_req_i), .wp_i(wp_i), .busy_o(busy_o),
        .rx_byte_o(m_byte), .rx_valid_o(m_valid));
    spi_eeprom_dev u_spi_eeprom_dev (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link_a.dev),
        .tx_data_i(tx_data_i), .tx_en_i(tx_en_i), .status_wr_i(status_wr_i),
        .status_bp_i(status_bp_i), .write_busy_i(write_busy_i), .rx_byte_o(d_byte),
        .rx_valid_o(d_valid), .rx_first_o(d_first), .tx_load_o(), .selected_o(sel),
        .hold_o(hold_o), .standby_o(standby_o), .iface_reset_o(),
        .protect_level_hi_o(bp_hi), .protect_level_lo_o(bp_lo));
    spi_eeprom_monitor u_spi_eeprom_monitor (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .sck(link_a.sck), .cs_n(link_a.cs_n), .mosi(link_a.mosi), .miso(link_a.miso),
        .miso_oe(link_a.miso_oe), .hold_n(link_a.hold_n), .wp_n(link_a.wp_n));

    always #10 mclk_i = ~mclk_i;

    // One-cycle pulses are caught here so no task can miss them
    always @(posedge mclk_i) begin
        if (m_valid === 1'b1) m_got <= m_byte;
        if (d_valid === 1'b1) begin
            d_got <= d_byte;
            d_first_got <= d_first;
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic [7:0] follow_byte(input logic [7:0] c);
        return c ^ 8'h5a;
    endfunction

    task automatic close_out();
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic send_byte(input logic [7:0] b, input logic last, input logic do_hold);
        int k;
        tx_byte_i = b;
        last_i = last;
        start_i = 1'b1;
        tick(1);
        start_i = 1'b0;
        if (do_hold) begin
            // Lands inside a clock low phase, where a pause may begin
            tick(20);
            hold_req_i = 1'b1;
            tick(40);
            chk1("hold state", 1'b1, hold_o);
            chk1("oe in hold", 1'b0, link_a.miso_oe);
            hold_req_i = 1'b0;
        end
        k = 0;
        while (busy_o !== 1'b0 && k < 400) begin
            tick(1);
            k++;
        end
        chk1("master busy", 1'b0, busy_o);
        tick(last ? 16 : 4);
    endtask

    task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input logic cpol,
                         input logic do_hold);
        cpol_i = cpol;
        tx_data_i = dat;
        tx_en_i = 1'b1;
        tick(4);
        send_byte(cmd, 1'b0, 1'b0);
        chk8("dev rx first", cmd, d_got);
        chk1("dev first flag", 1'b1, d_first_got);
        chk8("master rx idle", 8'hff, m_got);
        send_byte(follow_byte(cmd), 1'b1, do_hold);
        chk8("dev rx second", follow_byte(cmd), d_got);
        chk1("dev second flag", 1'b0, d_first_got);
        chk8("master rx read", dat, m_got);
        chk1("sck park", cpol, link_a.sck);
        chk1("oe after frame", 1'b0, link_a.miso_oe);
        chk1("selected", 1'b0, sel);
        chk1("standby", 1'b1, standby_o);
        tx_en_i = 1'b0;
    endtask

    task automatic set_protect(input logic [1:0] bp);
        status_bp_i = bp;
        status_wr_i = 1'b1;
        tick(1);
        status_wr_i = 1'b0;
        tick(8);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] c;
        logic [7:0] d;
        seed_ret = $urandom(3240);
        tick(10);
        chk1("standby in reset", 1'b1, standby_o);
        chk1("oe in reset", 1'b0, link_a.miso_oe);
        chk8("protect reset", 8'h00, {6'h00, bp_hi, bp_lo});
        tick(10);
        resetn_i = 1'b1;
        tick(2);
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($urandom);
            d = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom);
            frame(c, d, i[0], (i == 2 || i == 3));
        end
        write_busy_i = 1'b1;
        tick(6);
        chk1("standby busy", 1'b0, standby_o);
        write_busy_i = 1'b0;
        tick(6);
        chk1("standby idle", 1'b1, standby_o);
        set_protect(2'b10);
        chk8("protect open", 8'h02, {6'h00, bp_hi, bp_lo});
        wp_i = 1'b1;
        tick(8);
        set_protect(2'b01);
        chk8("protect locked", 8'h02, {6'h00, bp_hi, bp_lo});
        wp_i = 1'b0;
        tick(8);
        set_protect(2'b01);
        chk8("protect reopened", 8'h01, {6'h00, bp_hi, bp_lo});
        close_out();
    end

    // Six frames need about two thousand cycles; this allows ten times that
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule // tb
